// ===== hdl/gpc_cfg.svh
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH
// register selectors on the local access port
`define GPC_SEL_DIR        3'h0
`define GPC_SEL_LATCH      3'h1
`define GPC_SEL_LEVEL      3'h2
`define GPC_SEL_ODC        3'h3
`define GPC_SEL_ANSEL      3'h4
`define GPC_SEL_CNEN       3'h5
`define GPC_SEL_PU         3'h6
`define GPC_SEL_PD         3'h7
// alias offsets, in words of the byte offsets 0x4, 0x8, 0xc
`define GPC_OP_BASE        2'h0
`define GPC_OP_CLR         2'h1
`define GPC_OP_SET         2'h2
`define GPC_OP_INV         2'h3
// reset values
`define GPC_RST_DIR        16'hffff
`define GPC_RST_ANSEL      16'hffff
`define GPC_RST_ZERO       16'h0000
`define GPC_ALIAS_RDATA    16'h0000
`endif

// ===== hdl/gpc_pkg.sv
package gpc_pkg;
  typedef enum logic [1:0] {
    GPC_OP_BASE_E = 2'b00,
    GPC_OP_CLR_E  = 2'b01,
    GPC_OP_SET_E  = 2'b10,
    GPC_OP_INV_E  = 2'b11
  } gpc_op_t;
endpackage

// ===== hdl/gpc_bitreg.sv
`timescale 1ns/100ps
`include "gpc_cfg.svh"
module gpc_bitreg #(
  parameter int          W     = 16,
  parameter logic [15:0] RST_V = 16'h0000
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // write side
  input  wire logic         wr_en,
  input  wire logic [1:0]   wr_op,
  input  wire logic [W-1:0] wr_data,
  // stored value
  output logic      [W-1:0] q
);
  logic [W-1:0] q_nxt;

  // base write stores, aliases touch only bits written as 1
  always_comb begin
    q_nxt = q;
    if (wr_en) begin
      case (gpc_pkg::gpc_op_t'(wr_op))
        gpc_pkg::GPC_OP_BASE_E: q_nxt = wr_data;
        gpc_pkg::GPC_OP_CLR_E:  q_nxt = q & ~wr_data;
        gpc_pkg::GPC_OP_SET_E:  q_nxt = q | wr_data;
        gpc_pkg::GPC_OP_INV_E:  q_nxt = q ^ wr_data;
        default:                q_nxt = q;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RST_V[W-1:0];
    end else begin
      q <= q_nxt;
    end
  end
endmodule // gpc_bitreg

// ===== hdl/gpc_port.sv
`timescale 1ns/100ps
`include "gpc_cfg.svh"
// Summary of operation
// - direction bit one makes pin input
// - reset makes every pin an input
// - latch reads latch, writes latch
// - level reads pins, writes go latch
// - open drain drives low only
// - analog select resets to all ones
// - analog output still drives latched level
// - analog pins read zero from level
// - change detection needs the clock running
// - only enabled pins raise change request
// - flag marks change since level read
// - separate weak pullup and pulldown enables
// - clear, set, invert aliases per register
// - alias reads return undefined data
module gpc_port #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // register access
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [2:0]   reg_sel,
  input  wire logic [1:0]   reg_op,
  input  wire logic [W-1:0] reg_wdata,
  output logic      [W-1:0] reg_rdata,
  output logic              reg_rvalid,
  // pads
  input  wire logic [W-1:0] pad_in,
  output logic      [W-1:0] pad_out,
  output logic      [W-1:0] pad_oe,
  output logic      [W-1:0] pullup_en,
  output logic      [W-1:0] pulldown_en,
  output logic      [W-1:0] analog_en,
  // change notification
  output logic      [W-1:0] change_notify_flags,
  output logic              change_notification_irq
);
  logic [W-1:0] pin_direction;
  logic [W-1:0] output_latch;
  logic [W-1:0] open_drain_select;
  logic [W-1:0] analog_select;
  logic [W-1:0] change_notify_enable;
  logic [W-1:0] weak_pullup_enable;
  logic [W-1:0] weak_pulldown_enable;
  logic [W-1:0] sync1_r;
  logic [W-1:0] sync2_r;
  logic [W-1:0] prev_r;
  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;
  logic [W-1:0] rdata_r;
  logic [W-1:0] rdata_nxt;
  logic         rvalid_r;
  logic [W-1:0] pad_out_r;
  logic [W-1:0] pad_oe_r;
  logic [W-1:0] pu_r;
  logic [W-1:0] pd_r;
  logic [W-1:0] an_r;
  logic         irq_r;
  logic [2:0]   armed_r;

  function automatic logic wr_hit(input logic wr, input logic [2:0] sel, input logic [2:0] s);
    return wr && (sel == s);
  endfunction

  wire          wr_dir   = wr_hit(reg_wr, reg_sel, `GPC_SEL_DIR);
  // writes to the level register land in the latch
  wire          wr_lat   = wr_hit(reg_wr, reg_sel, `GPC_SEL_LATCH) ||
                           wr_hit(reg_wr, reg_sel, `GPC_SEL_LEVEL);
  wire          wr_odc   = wr_hit(reg_wr, reg_sel, `GPC_SEL_ODC);
  wire          wr_ans   = wr_hit(reg_wr, reg_sel, `GPC_SEL_ANSEL);
  wire          wr_cne   = wr_hit(reg_wr, reg_sel, `GPC_SEL_CNEN);
  wire          wr_pu    = wr_hit(reg_wr, reg_sel, `GPC_SEL_PU);
  wire          wr_pd    = wr_hit(reg_wr, reg_sel, `GPC_SEL_PD);
  wire          rd_level = reg_rd && (reg_sel == `GPC_SEL_LEVEL) && (reg_op == `GPC_OP_BASE);
  wire [W-1:0]  level_rd = sync2_r & ~analog_select;
  // history flops start from zero, so compare only once they hold real pin samples
  wire [W-1:0]  changed  = (sync2_r ^ prev_r) & pin_direction & {W{armed_r[2]}}; // input pins only
  // an open-drain pin drives only its low level and floats otherwise
  wire [W-1:0]  drive_val = output_latch & ~open_drain_select;
  wire [W-1:0]  drive_en  = ~pin_direction & (~open_drain_select | ~output_latch);
  wire          irq_any   = |(flags_nxt & change_notify_enable);

  // direction comes up all ones, so no pin drives before software asks it to
  gpc_bitreg #(.W(W), .RST_V(`GPC_RST_DIR)) u_dir (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_dir),
    .wr_op   (reg_op),
    .wr_data (reg_wdata),
    .q       (pin_direction)
  );

  gpc_bitreg #(.W(W), .RST_V(`GPC_RST_ZERO)) u_lat (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_lat),
    .wr_op   (reg_op),
    .wr_data (reg_wdata),
    .q       (output_latch)
  );

  gpc_bitreg #(.W(W), .RST_V(`GPC_RST_ZERO)) u_odc (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_odc),
    .wr_op   (reg_op),
    .wr_data (reg_wdata),
    .q       (open_drain_select)
  );

  // analog by default keeps digital input buffers quiet until a pin is claimed
  gpc_bitreg #(.W(W), .RST_V(`GPC_RST_ANSEL)) u_ans (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_ans),
    .wr_op   (reg_op),
    .wr_data (reg_wdata),
    .q       (analog_select)
  );

  gpc_bitreg #(.W(W), .RST_V(`GPC_RST_ZERO)) u_cne (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_cne),
    .wr_op   (reg_op),
    .wr_data (reg_wdata),
    .q       (change_notify_enable)
  );

  gpc_bitreg #(.W(W), .RST_V(`GPC_RST_ZERO)) u_pu (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_pu),
    .wr_op   (reg_op),
    .wr_data (reg_wdata),
    .q       (weak_pullup_enable)
  );

  gpc_bitreg #(.W(W), .RST_V(`GPC_RST_ZERO)) u_pd (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_pd),
    .wr_op   (reg_op),
    .wr_data (reg_wdata),
    .q       (weak_pulldown_enable)
  );

  // read mux; alias reads give a fixed zero, software must not rely on it
  always_comb begin
    rdata_nxt = `GPC_ALIAS_RDATA;
    if (reg_op == `GPC_OP_BASE) begin
      case (reg_sel)
        `GPC_SEL_DIR:   rdata_nxt = pin_direction;
        `GPC_SEL_LATCH: rdata_nxt = output_latch;
        `GPC_SEL_LEVEL: rdata_nxt = level_rd;
        `GPC_SEL_ODC:   rdata_nxt = open_drain_select;
        `GPC_SEL_ANSEL: rdata_nxt = analog_select;
        `GPC_SEL_CNEN:  rdata_nxt = change_notify_enable;
        `GPC_SEL_PU:    rdata_nxt = weak_pullup_enable;
        `GPC_SEL_PD:    rdata_nxt = weak_pulldown_enable;
        default:        rdata_nxt = `GPC_ALIAS_RDATA;
      endcase
    end
  end

  // a change in the same cycle as the level read wins over the clear
  assign flags_nxt = (rd_level ? `GPC_RST_ZERO : flags_r) | changed;

  // sampled detection only; with the clock stopped the pad-ring wake logic must cover it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= `GPC_RST_ZERO;
      sync2_r <= `GPC_RST_ZERO;
      prev_r  <= `GPC_RST_ZERO;
      flags_r <= `GPC_RST_ZERO;
      armed_r <= 3'h0;
    end else begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      flags_r <= flags_nxt;
      armed_r <= {armed_r[1:0], 1'b1};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r   <= `GPC_RST_ZERO;
      rvalid_r  <= 1'b0;
      pad_out_r <= `GPC_RST_ZERO;
      pad_oe_r  <= `GPC_RST_ZERO;
      pu_r      <= `GPC_RST_ZERO;
      pd_r      <= `GPC_RST_ZERO;
      an_r      <= `GPC_RST_ANSEL;
      irq_r     <= 1'b0;
    end else begin
      rdata_r   <= reg_rd ? rdata_nxt : rdata_r;
      rvalid_r  <= reg_rd;
      pad_out_r <= drive_val;
      pad_oe_r  <= drive_en;
      pu_r      <= weak_pullup_enable;
      pd_r      <= weak_pulldown_enable;
      an_r      <= analog_select;
      irq_r     <= irq_any;
    end
  end

  assign reg_rdata               = rdata_r;
  assign reg_rvalid              = rvalid_r;
  assign pad_out                 = pad_out_r;
  assign pad_oe                  = pad_oe_r;
  assign pullup_en               = pu_r;
  assign pulldown_en             = pd_r;
  assign analog_en               = an_r;
  assign change_notify_flags     = flags_r;
  assign change_notification_irq = irq_r;
endmodule // gpc_port

// ===== tb/gpc_pads_model.sv
`timescale 1ns/100ps
module gpc_pads_model (
  // clock
  input  wire logic        clk,
  // port side
  input  wire logic [15:0] pad_out,
  input  wire logic [15:0] pad_oe,
  input  wire logic [15:0] pullup_en,
  input  wire logic [15:0] pulldown_en,
  // board drive
  input  wire logic [15:0] ext_en,
  input  wire logic [15:0] ext_val,
  output logic      [15:0] pad_in
);
  // floating pins wander each cycle; the pulls check reads them high, so a missed pulldown fails but a missed pullup still matches
  logic [15:0] tgl = 16'h0000;
  always_ff @(posedge clk) tgl <= ~tgl;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
                  (~pad_oe & ~ext_en & (pullup_en | (~pulldown_en & tgl)));
endmodule // gpc_pads_model

// ===== tb/gpc_port_asserts.sv
`timescale 1ns/100ps
module gpc_port_asserts #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic         clk,
  input wire logic         rst,
  // register access
  input wire logic         reg_rd,
  input wire logic         reg_wr,
  input wire logic [2:0]   reg_sel,
  input wire logic [1:0]   reg_op,
  input wire logic [W-1:0] reg_rdata,
  input wire logic         reg_rvalid,
  // pads and flags
  input wire logic [W-1:0] pad_in,
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe,
  input wire logic [W-1:0] pullup_en,
  input wire logic [W-1:0] pulldown_en,
  input wire logic [W-1:0] analog_en,
  input wire logic [W-1:0] change_notify_flags,
  input wire logic         change_notification_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer timing");
  a_alias_read: assert property (reg_rd && reg_op != 2'h0 |=> reg_rdata == '0)
    else $error("alias read not zero");
  a_analog_zero: assert property (reg_rd && reg_sel == 3'h2 && reg_op == 2'h0 |=>
    (!$stable(analog_en) || (reg_rdata & analog_en) == '0)) else $error("analog pin read high");
  a_reset_state: assert property ($fell(rst) |-> pad_oe == '0 && analog_en == '1)
    else $error("reset state wrong");
  a_flag_clear: assert property (|($past(change_notify_flags) & ~change_notify_flags) |->
    $past(reg_rd && reg_sel == 3'h2 && reg_op == 2'h0)) else $error("flag lost without read");
  a_flag_cause: assert property (|(change_notify_flags & ~$past(change_notify_flags)) |->
    ($past(pad_in, 2) != $past(pad_in, 3)) || ($past(pad_in, 3) != $past(pad_in, 4)))
    else $error("flag without pin change");
  a_drive_cause: assert property ($changed({pad_out, pad_oe}) |-> $past(reg_wr, 2))
    else $error("drive changed without write");
  a_pull_cause: assert property ($changed({pullup_en, pulldown_en}) |-> $past(reg_wr, 2))
    else $error("pull changed without write");
  a_irq_flags: assert property (change_notification_irq |-> change_notify_flags != '0)
    else $error("request without flag");
endmodule // gpc_port_asserts
bind gpc_port gpc_port_asserts #(.W(W)) u_chk (
  .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_op(reg_op),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
  .pullup_en(pullup_en), .pulldown_en(pulldown_en), .analog_en(analog_en),
  .change_notify_flags(change_notify_flags), .change_notification_irq(change_notification_irq));

// ===== tb/gpio_port_with_change_notify_tb_top.sv
`timescale 1ns/100ps
module gpio_port_with_change_notify_tb_top;
  logic        clk, rst, reg_wr, reg_rd, reg_rvalid, irq;
  logic [2:0]  reg_sel;
  logic [1:0]  reg_op;
  logic [15:0] reg_wdata, reg_rdata, pad_in, pad_out, pad_oe, pu, pd, an, flags, ext_en, ext_val;
  int          n_errors, tests_run, cyc;
  gpc_port #(.W(16)) u_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
    .reg_op(reg_op), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pu), .pulldown_en(pd),
    .analog_en(an), .change_notify_flags(flags), .change_notification_irq(irq));
  gpc_pads_model u_pads (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pu),
    .pulldown_en(pd), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  always #5 clk = ~clk;
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [1:0] o, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_sel <= s;
    reg_op <= o;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, input logic [1:0] o, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_sel <= s;
    reg_op <= o;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    chk({15'h0, reg_rvalid}, 16'h0001);
  endtask
  // a hang past this many cycles counts as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    {clk, rst, reg_wr, reg_rd, reg_sel, reg_op, reg_wdata} = {2'b01, 23'h0};
    {n_errors, tests_run, cyc} = '0;
    ext_en = 16'hffff;
    ext_val = 16'ha500;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(3'h0, 2'h0, 16'hffff);
    rd(3'h4, 2'h0, 16'hffff);
    chk(pad_oe, 16'h0000);
    $display("test reset done");
    wr(3'h4, 2'h0, 16'h0000);
    wr(3'h1, 2'h2, 16'h00f0);
    wr(3'h1, 2'h1, 16'h0030);
    rd(3'h1, 2'h0, 16'h00c0);
    rd(3'h1, 2'h2, 16'h0000);
    wr(3'h0, 2'h0, 16'hff00);
    // pad changes reach the level path two flops after the pad register
    repeat (2) @(posedge clk);
    rd(3'h2, 2'h0, 16'ha5c0);
    chk(pad_oe, 16'h00ff);
    wr(3'h2, 2'h0, 16'h0003);
    wr(3'h3, 2'h2, 16'h0001);
    wr(3'h0, 2'h3, 16'h0f00);
    rd(3'h1, 2'h0, 16'h0003);
    chk(pad_out, 16'h0002);
    chk(pad_oe, 16'h0ffe);
    rd(3'h2, 2'h0, 16'ha002);
    $display("test latch done");
    wr(3'h3, 2'h1, 16'h0001);
    wr(3'h4, 2'h0, 16'h8001);
    rd(3'h2, 2'h0, 16'h2002);
    chk(pad_out, 16'h0003);
    chk(pad_oe, 16'h0fff);
    chk(an, 16'h8001);
    $display("test analog done");
    wr(3'h5, 2'h0, 16'h1000);
    rd(3'h2, 2'h0, 16'h2002);
    @(posedge clk) ext_val <= 16'h9500;
    repeat (6) @(posedge clk);
    #1;
    chk(flags, 16'h3000);
    chk({15'h0, irq}, 16'h0001);
    rd(3'h2, 2'h0, 16'h1002);
    @(posedge clk) ext_val <= 16'hb500;
    repeat (6) @(posedge clk);
    #1;
    chk({14'h0, flags[13], irq}, 16'h0002);
    rd(3'h2, 2'h0, 16'h3002);
    chk(flags, 16'h0000);
    $display("test notify done");
    wr(3'h6, 2'h0, 16'h4000);
    wr(3'h7, 2'h0, 16'h2000);
    ext_en <= 16'h9fff;
    repeat (2) @(posedge clk);
    rd(3'h2, 2'h0, 16'h5002);
    chk(pu, 16'h4000);
    chk(pd, 16'h2000);
    $display("test pulls done");
    @(posedge clk) ext_en <= 16'hffff;
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rd(3'h0, 2'h0, 16'hffff);
    chk(pad_oe, 16'h0000);
    repeat (4) @(posedge clk);
    #1;
    chk(flags, 16'h0000);
    rd(3'h2, 2'h0, 16'h0000);
    $display("test reset again done");
    report_and_stop();
  end
endmodule // gpio_port_with_change_notify_tb_top
